// ==== verilog/iag_pkg.sv ====
// Constants and carrier types for the indirect operand address generator
package iag_pkg;
  localparam int WORD_W = 32;
  localparam int ARITH_W = 24;
  localparam int DISP_W = 8;
  localparam int MOD_W = 5;
  localparam int SEL_W = 3;
  localparam int NUM_PTR = 8;
  localparam int TGT_W = 4;

  // Modification field layout
  localparam int MOD_SUB_BIT = 0;
  localparam int MOD_KIND_LO = 1;
  localparam int MOD_KIND_HI = 2;
  localparam int MOD_GRP_LO = 3;
  localparam int MOD_GRP_HI = 4;

  // Step source groups (mod[4:3])
  localparam logic [1:0] GRP_DISP = 2'h0;
  localparam logic [1:0] GRP_IDX0 = 2'h1;
  localparam logic [1:0] GRP_IDX1 = 2'h2;
  localparam logic [1:0] GRP_SPECIAL = 2'h3;

  // Update kinds (mod[2:1])
  localparam logic [1:0] KIND_PRE = 2'h0;
  localparam logic [1:0] KIND_PRE_MOD = 2'h1;
  localparam logic [1:0] KIND_POST = 2'h2;
  localparam logic [1:0] KIND_POST_CIRC = 2'h3;

  // Named modification codes
  localparam logic [4:0] MOD_PRE_DISP_ADD = 5'h00;
  localparam logic [4:0] MOD_PRE_DISP_SUB = 5'h01;
  localparam logic [4:0] MOD_PRE_DISP_ADD_MOD = 5'h02;
  localparam logic [4:0] MOD_POST_DISP_ADD = 5'h04;
  localparam logic [4:0] MOD_POST_DISP_ADD_CIRC = 5'h06;
  localparam logic [4:0] MOD_PRE_IDX0_ADD = 5'h08;
  localparam logic [4:0] MOD_PRE_IDX0_SUB = 5'h09;
  localparam logic [4:0] MOD_PRE_IDX0_ADD_MOD = 5'h0A;
  localparam logic [4:0] MOD_POST_IDX0_ADD = 5'h0C;
  localparam logic [4:0] MOD_PRE_IDX1_ADD = 5'h10;
  localparam logic [4:0] MOD_PLAIN = 5'h18;
  localparam logic [4:0] MOD_BITREV = 5'h19;

  localparam logic [23:0] IMPLICIT_DISP = 24'h000001;

  // Load targets
  localparam logic [3:0] TGT_INDEX_ZERO = 4'h8;
  localparam logic [3:0] TGT_INDEX_ONE = 4'h9;
  localparam logic [3:0] TGT_BLOCK_SIZE = 4'hA;

  localparam logic [31:0] REG_RESET = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic [4:0] mod;
    logic [2:0] ptr_sel;
    logic [7:0] disp;
    logic disp_given;
  } addr_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] target;
    logic [31:0] data;
  } reg_load_t;
endpackage

// ==== verilog/indirect_address_generator.sv ====
// Indirect operand address generator with pointer update unit
`timescale 1ns/1ps
module indirect_address_generator (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Address request from decode
  input wire iag_pkg::addr_req_t req,
  // Register load from the core
  input wire iag_pkg::reg_load_t load,
  // Readback select: 0..7 pointers, 8/9 index, 10 block size
  input wire logic [3:0] read_sel,
  // Operand address to data memory
  output logic addr_valid,
  output logic [31:0] operand_addr,
  // Readback
  output logic [31:0] read_data
);

  logic [31:0] aux_pointer [iag_pkg::NUM_PTR];
  logic [31:0] index_reg_zero;
  logic [31:0] index_reg_one;
  logic [31:0] circ_block_size;
  logic addr_valid_reg;
  logic [31:0] operand_addr_reg;
  logic [31:0] read_data_reg;

  function automatic logic [23:0] rev24(input logic [23:0] v);
    logic [23:0] r;
    r = 24'h000000;
    for (int i = 0; i < iag_pkg::ARITH_W; i++) begin
      r[i] = v[iag_pkg::ARITH_W - 1 - i];
    end
    return r;
  endfunction

  // Ones at and below the top set bit: the K-bit boundary mask with 2^K > size
  function automatic logic [23:0] smear24(input logic [23:0] v);
    logic [23:0] r;
    r = v;
    for (int i = 1; i < iag_pkg::ARITH_W; i++) begin
      r[iag_pkg::ARITH_W - 1 - i] = r[iag_pkg::ARITH_W - 1 - i] | r[iag_pkg::ARITH_W - i];
    end
    return r;
  endfunction

  // Mode decode
  wire [1:0] grp = req.mod[iag_pkg::MOD_GRP_HI:iag_pkg::MOD_GRP_LO];
  wire [1:0] kind = req.mod[iag_pkg::MOD_KIND_HI:iag_pkg::MOD_KIND_LO];
  wire is_sub = req.mod[iag_pkg::MOD_SUB_BIT];
  wire is_special = (grp == iag_pkg::GRP_SPECIAL);
  wire is_bitrev = (req.mod == iag_pkg::MOD_BITREV);

  // Operands
  wire [31:0] ptr_cur = aux_pointer[req.ptr_sel];
  wire [23:0] lo = ptr_cur[23:0];
  wire [23:0] disp_eff = req.disp_given ? {16'h0000, req.disp} : iag_pkg::IMPLICIT_DISP;
  wire [23:0] step = (grp == iag_pkg::GRP_DISP) ? disp_eff :
                     (grp == iag_pkg::GRP_IDX1) ? index_reg_one[23:0] :
                     index_reg_zero[23:0];
  wire [23:0] lin = is_sub ? lo - step : lo + step;

  // Circular update; step is assumed not above the block size
  wire [23:0] bk = circ_block_size[23:0];
  wire [23:0] cmask = smear24(bk);
  wire [23:0] cidx = lo & cmask;
  wire [24:0] craw = is_sub ? {1'b0, cidx} - {1'b0, step} : {1'b0, cidx} + {1'b0, step};
  wire c_over = !is_sub && (craw >= {1'b0, bk});
  wire c_under = is_sub && craw[24];
  wire [24:0] cfix = c_over ? craw - {1'b0, bk} : (c_under ? craw + {1'b0, bk} : craw);
  wire [23:0] circ = (lo & ~cmask) | (cfix[23:0] & cmask);

  // Reverse-carry add: carries walk from msb toward bit zero and fall off there
  wire [23:0] brev = rev24(rev24(lo) + rev24(index_reg_zero[23:0]));

  // Address and update selection
  wire use_ptr_addr = is_special || kind[1];
  wire [23:0] addr_lo = use_ptr_addr ? lo : lin;
  wire [23:0] upd_lo = is_special ? brev :
                       (kind == iag_pkg::KIND_POST_CIRC) ? circ : lin;
  wire upd_en = req.valid && (is_special ? is_bitrev : (kind != iag_pkg::KIND_PRE));
  wire [31:0] upd_word = {ptr_cur[31:24], upd_lo};

  wire [31:0] read_mux = (read_sel == iag_pkg::TGT_INDEX_ZERO) ? index_reg_zero :
                         (read_sel == iag_pkg::TGT_INDEX_ONE) ? index_reg_one :
                         (read_sel == iag_pkg::TGT_BLOCK_SIZE) ? circ_block_size :
                         (read_sel[3] == 1'b0) ? aux_pointer[read_sel[2:0]] :
                         32'h00000000;

  wire ld_idx0 = load.valid && (load.target == iag_pkg::TGT_INDEX_ZERO);
  wire ld_idx1 = load.valid && (load.target == iag_pkg::TGT_INDEX_ONE);
  wire ld_bk = load.valid && (load.target == iag_pkg::TGT_BLOCK_SIZE);

  // A core load to the same pointer in the same cycle overrides the update
  genvar g;
  generate
    for (g = 0; g < iag_pkg::NUM_PTR; g++) begin : g_ptr
      wire ld_me = load.valid && (load.target == 4'(g));
      wire up_me = upd_en && (req.ptr_sel == 3'(g));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          aux_pointer[g] <= iag_pkg::REG_RESET;
        end else if (ld_me) begin
          aux_pointer[g] <= load.data;
        end else if (up_me) begin
          aux_pointer[g] <= upd_word;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      index_reg_zero <= iag_pkg::REG_RESET;
      index_reg_one <= iag_pkg::REG_RESET;
      circ_block_size <= iag_pkg::REG_RESET;
    end else begin
      if (ld_idx0) begin
        index_reg_zero <= load.data;
      end
      if (ld_idx1) begin
        index_reg_one <= load.data;
      end
      if (ld_bk) begin
        circ_block_size <= load.data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_valid_reg <= 1'b0;
      operand_addr_reg <= iag_pkg::REG_RESET;
      read_data_reg <= iag_pkg::REG_RESET;
    end else begin
      addr_valid_reg <= req.valid;
      operand_addr_reg <= req.valid ? {ptr_cur[31:24], addr_lo} : operand_addr_reg;
      read_data_reg <= read_mux;
    end
  end

  assign addr_valid = addr_valid_reg;
  assign operand_addr = operand_addr_reg;
  assign read_data = read_data_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_take(logic [4:0] code);
    req.valid && !load.valid && (req.mod == code);
  endsequence

  property p_disp_implicit;
    s_take(iag_pkg::MOD_PRE_DISP_ADD) and !req.disp_given |=>
      addr_valid && (operand_addr[23:0] == 24'($past(lo) + 24'h000001));
  endproperty
  a_disp_implicit: assert property (p_disp_implicit) else $error("implicit displacement wrong");

  property p_pre_add;
    s_take(iag_pkg::MOD_PRE_DISP_ADD) and req.disp_given |=>
      (operand_addr[23:0] == 24'($past(lo) + {16'h0000, $past(req.disp)}))
      && (aux_pointer[$past(req.ptr_sel)] == $past(ptr_cur));
  endproperty
  a_pre_add: assert property (p_pre_add) else $error("predisplacement add wrong");

  property p_pre_sub;
    s_take(iag_pkg::MOD_PRE_DISP_SUB) and req.disp_given |=>
      (operand_addr[23:0] == 24'($past(lo) - {16'h0000, $past(req.disp)}))
      && (aux_pointer[$past(req.ptr_sel)] == $past(ptr_cur));
  endproperty
  a_pre_sub: assert property (p_pre_sub) else $error("predisplacement subtract wrong");

  property p_pre_mod;
    s_take(iag_pkg::MOD_PRE_DISP_ADD_MOD) |=>
      aux_pointer[$past(req.ptr_sel)][23:0] == operand_addr[23:0];
  endproperty
  a_pre_mod: assert property (p_pre_mod) else $error("modify write-back differs");

  property p_post_disp;
    s_take(iag_pkg::MOD_POST_DISP_ADD) |=>
      (operand_addr == $past(ptr_cur))
      && (aux_pointer[$past(req.ptr_sel)][23:0] == 24'($past(lo) + $past(disp_eff)));
  endproperty
  a_post_disp: assert property (p_post_disp) else $error("postdisplacement wrong");

  property p_circ;
    s_take(iag_pkg::MOD_POST_DISP_ADD_CIRC) and (cidx < bk) |=>
      (operand_addr == $past(ptr_cur))
      && ((aux_pointer[$past(req.ptr_sel)][23:0] & cmask) < bk)
      && ((aux_pointer[$past(req.ptr_sel)][23:0] & ~cmask) == ($past(lo) & ~cmask));
  endproperty
  a_circ: assert property (p_circ) else $error("circular update outside buffer");

  property p_preindex;
    s_take(iag_pkg::MOD_PRE_IDX1_ADD) |=>
      operand_addr[23:0] == 24'($past(lo) + index_reg_one[23:0]);
  endproperty
  a_preindex: assert property (p_preindex) else $error("preindex add wrong");

  property p_postindex;
    s_take(iag_pkg::MOD_POST_IDX0_ADD) |=>
      aux_pointer[$past(req.ptr_sel)][23:0] == 24'($past(lo) + index_reg_zero[23:0]);
  endproperty
  a_postindex: assert property (p_postindex) else $error("postindex add wrong");

  property p_plain;
    s_take(iag_pkg::MOD_PLAIN) |=>
      (operand_addr == $past(ptr_cur)) && $stable(aux_pointer[$past(req.ptr_sel)]);
  endproperty
  a_plain: assert property (p_plain) else $error("plain indirect changed pointer");

  property p_upper;
    req.valid && !load.valid |=>
      aux_pointer[$past(req.ptr_sel)][31:24] == $past(ptr_cur[31:24]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper pointer bits modified");

  // Step of one at the msb: bit 23 flips, and only a carry out of it may touch bit 22
  property p_bitrev;
    s_take(iag_pkg::MOD_BITREV) and (index_reg_zero[23:0] == 24'h800000) |=>
      (aux_pointer[$past(req.ptr_sel)][23] != $past(lo[23]))
      && ($past(lo[23]) || (aux_pointer[$past(req.ptr_sel)][22:0] == $past(lo[22:0])))
      && (!$past(lo[23]) || (aux_pointer[$past(req.ptr_sel)][22] != $past(lo[22])));
  endproperty
  a_bitrev: assert property (p_bitrev) else $error("bit-reversed step wrong");

  property p_only_sel;
    req.valid && !load.valid ##0 (req.ptr_sel != 3'h0) |=> $stable(aux_pointer[0]);
  endproperty
  a_only_sel: assert property (p_only_sel) else $error("unselected pointer modified");

endmodule

// ==== tb/operand_sink.sv ====
// Data memory side model: takes each operand address the generator issues
`timescale 1ns/1ps
module operand_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Address from the generator
  input wire logic addr_valid,
  input wire logic [31:0] operand_addr,
  // Capture seen by the bench
  output logic [31:0] last_addr,
  output logic [7:0] fetch_cnt
);
  // Counting fetches lets the bench notice a missing or doubled strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_addr <= 32'h00000000;
      fetch_cnt <= 8'h00;
    end else if (addr_valid) begin
      last_addr <= operand_addr;
      fetch_cnt <= fetch_cnt + 8'h01;
    end
  end
endmodule

// ==== tb/indirect_address_generator_bench.sv ====
// Self-checking bench for the indirect operand address generator
`timescale 1ns/1ps
module indirect_address_generator_bench;
  logic clk;
  logic nrst;
  iag_pkg::addr_req_t req;
  iag_pkg::reg_load_t load;
  logic [3:0] read_sel;
  logic addr_valid;
  logic [31:0] operand_addr;
  logic [31:0] read_data;
  logic [31:0] last_addr;
  logic [7:0] fetch_cnt;
  int miscompares;
  int n_checks;

  indirect_address_generator u_indirect_address_generator (.clk(clk), .nrst(nrst), .req(req),
    .load(load), .read_sel(read_sel), .addr_valid(addr_valid), .operand_addr(operand_addr),
    .read_data(read_data));
  operand_sink u_operand_sink (.clk(clk), .nrst(nrst), .addr_valid(addr_valid),
    .operand_addr(operand_addr), .last_addr(last_addr), .fetch_cnt(fetch_cnt));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] t, input logic [31:0] d);
    load = '{valid: 1'b1, target: t, data: d};
    @(posedge clk);
    #2;
    load.valid = 1'b0;
    // Let an edge pass so a following load does not reassign valid in this step
    @(posedge clk);
    #2;
  endtask

  task automatic rd(input logic [3:0] t, input logic [31:0] e);
    read_sel = t;
    @(posedge clk);
    #2;
    chk("read_data", e, read_data);
  endtask

  // One request; addr checked at the memory side, pointer read back after update
  task automatic step(input logic [4:0] m, input logic [2:0] s, input logic [7:0] d,
                      input logic g, input logic [31:0] ea, input logic [31:0] ep);
    logic [7:0] old;
    int n;
    old = fetch_cnt;
    n = 0;
    req = '{valid: 1'b1, mod: m, ptr_sel: s, disp: d, disp_given: g};
    @(posedge clk);
    #2;
    req.valid = 1'b0;
    read_sel = {1'b0, s};
    while (fetch_cnt === old && n < 4) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (fetch_cnt === old) begin
      miscompares++;
      complete_run();
    end
    chk("addr_latency", 32'h00000001, 32'(n));
    chk("fetch_cnt", {24'h000000, old + 8'h01}, {24'h000000, fetch_cnt});
    chk("operand_addr", ea, last_addr);
    chk("aux_pointer", ep, read_data);
  endtask

  task automatic t_disp();
    wr(4'h0, 32'h00000077);
    wr(4'h2, 32'hAB000010);
    step(5'h00, 3'h2, 8'h05, 1'b1, 32'hAB000015, 32'hAB000010);
    step(5'h01, 3'h2, 8'h05, 1'b0, 32'hAB00000F, 32'hAB000010);
    step(5'h01, 3'h2, 8'h05, 1'b1, 32'hAB00000B, 32'hAB000010);
    step(5'h00, 3'h2, 8'h05, 1'b0, 32'hAB000011, 32'hAB000010);
    step(5'h02, 3'h2, 8'h05, 1'b1, 32'hAB000015, 32'hAB000015);
    step(5'h03, 3'h2, 8'h05, 1'b0, 32'hAB000014, 32'hAB000014);
    step(5'h04, 3'h2, 8'hFF, 1'b1, 32'hAB000014, 32'hAB000113);
    step(5'h05, 3'h2, 8'hFF, 1'b1, 32'hAB000113, 32'hAB000014);
    rd(4'h0, 32'h00000077);
  endtask

  // Carry out of bit 23 must not reach the upper byte
  task automatic t_wrap();
    wr(4'h5, 32'hFFFFFFFF);
    step(5'h04, 3'h5, 8'h00, 1'b0, 32'hFFFFFFFF, 32'hFF000000);
    step(5'h05, 3'h5, 8'h00, 1'b0, 32'hFF000000, 32'hFFFFFFFF);
  endtask

  task automatic t_index();
    wr(4'h8, 32'h00000003);
    wr(4'h9, 32'h00000010);
    wr(4'h3, 32'h00000100);
    step(5'h08, 3'h3, 8'h00, 1'b0, 32'h00000103, 32'h00000100);
    step(5'h09, 3'h3, 8'h00, 1'b0, 32'h000000FD, 32'h00000100);
    step(5'h10, 3'h3, 8'h00, 1'b0, 32'h00000110, 32'h00000100);
    step(5'h11, 3'h3, 8'h00, 1'b0, 32'h000000F0, 32'h00000100);
    step(5'h0A, 3'h3, 8'h00, 1'b0, 32'h00000103, 32'h00000103);
    step(5'h0B, 3'h3, 8'h00, 1'b0, 32'h00000100, 32'h00000100);
    step(5'h12, 3'h3, 8'h00, 1'b0, 32'h00000110, 32'h00000110);
    step(5'h13, 3'h3, 8'h00, 1'b0, 32'h00000100, 32'h00000100);
    step(5'h0C, 3'h3, 8'h00, 1'b0, 32'h00000100, 32'h00000103);
    step(5'h0D, 3'h3, 8'h00, 1'b0, 32'h00000103, 32'h00000100);
    step(5'h14, 3'h3, 8'h00, 1'b0, 32'h00000100, 32'h00000110);
    step(5'h15, 3'h3, 8'h00, 1'b0, 32'h00000110, 32'h00000100);
    step(5'h18, 3'h3, 8'h09, 1'b1, 32'h00000100, 32'h00000100);
    step(5'h1B, 3'h3, 8'h09, 1'b1, 32'h00000100, 32'h00000100);
  endtask

  // Six-entry buffer aligned at 0x40; bits above the buffer must survive
  task automatic t_circ();
    wr(4'hA, 32'h00000006);
    wr(4'h8, 32'h00000002);
    wr(4'h9, 32'h00000003);
    wr(4'h4, 32'h12000040);
    step(5'h06, 3'h4, 8'h05, 1'b1, 32'h12000040, 32'h12000045);
    step(5'h06, 3'h4, 8'h02, 1'b1, 32'h12000045, 32'h12000041);
    step(5'h07, 3'h4, 8'h03, 1'b1, 32'h12000041, 32'h12000044);
    step(5'h0E, 3'h4, 8'h00, 1'b0, 32'h12000044, 32'h12000040);
    step(5'h0F, 3'h4, 8'h00, 1'b0, 32'h12000040, 32'h12000044);
    step(5'h16, 3'h4, 8'h00, 1'b0, 32'h12000044, 32'h12000041);
    step(5'h17, 3'h4, 8'h00, 1'b0, 32'h12000041, 32'h12000044);
  endtask

  task automatic t_bitrev();
    wr(4'h8, 32'h00800000);
    wr(4'h1, 32'h3C000000);
    step(5'h19, 3'h1, 8'h00, 1'b0, 32'h3C000000, 32'h3C800000);
    step(5'h19, 3'h1, 8'h00, 1'b0, 32'h3C800000, 32'h3C400000);
    step(5'h19, 3'h1, 8'h00, 1'b0, 32'h3C400000, 32'h3CC00000);
    step(5'h19, 3'h1, 8'h00, 1'b0, 32'h3CC00000, 32'h3C200000);
  endtask

  initial begin
    miscompares = 0;
    n_checks = 0;
    nrst = 1'b0;
    req = '0;
    load = '0;
    read_sel = 4'h0;
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    t_disp();
    t_wrap();
    t_index();
    t_circ();
    t_bitrev();
    complete_run();
  end
endmodule
